/* pkg/spt_defines.svh */
// Constants for the S/PDIF transmit subframe builder: offsets, fields, resets, timing
//
// Function
// - Payload source: receiver if select 0, else audio
// - Power-down bit 2 disables transmitter, resets to 1
// - Audio source, no override: validity sent 0
// - Receiver source, no override: validity forwarded
// - Override bit 7 uses bits 5, 6
// - User bits zero unless both selects zero
// - Status one bit per subframe, 192-frame block
// - Status identical per subframe except channel numbers; code sends one vector, channel numbers included, to both
// - Status from receiver unless status-source set; code also sends register status when audio source is selected
// - Parity bit keeps subframe parity even
// - Subframe is preamble, payload, V, U, C, P
// - First status register maps to bits 7:0
// - Category register sent as status bits 15:8
// - Third register: source number, channel number fields
// - Hardware mode latches source from pin at reset
// - Reference clock: recovered clock or master clock pin
// - Channel number 01 left, 10 right; code inserts none, status bits 23:20 come from the register in both subframes
`ifndef SPT_DEFINES_SVH
`define SPT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPT_ADDR_VALIDITY 8'h06
`define SPT_ADDR_FORMAT 8'h12
`define SPT_ADDR_CATEGORY 8'h13
`define SPT_ADDR_SRC_CHAN 8'h14
`define SPT_ADDR_SOURCE 8'h15
`define SPT_ADDR_HIGH_RATE 8'h1D
`define SPT_ADDR_POWER 8'h1E

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPT_RST_VALIDITY 8'h00
`define SPT_RST_FORMAT 8'h00
`define SPT_RST_CATEGORY 8'h00
`define SPT_RST_SRC_CHAN 8'h00
`define SPT_RST_SOURCE 8'h71
`define SPT_RST_HIGH_RATE 8'h80
`define SPT_RST_POWER 8'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPT_VAL_SUB0_BIT 5
`define SPT_VAL_SUB1_BIT 6
`define SPT_VAL_OVR_BIT 7
`define SPT_SRC_BIT 6
`define SPT_STAT_SRC_BIT 7
`define SPT_TX_PD_BIT 2

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define SPT_SAMPLE_W 24
`define SPT_WORD_W 27
`define SPT_FIFO_DEPTH 16
`define SPT_BLOCK_LAST 8'hBF
`define SPT_CS_USED 8'h28
`define SPT_PRE_HALVES 6'h08
`define SPT_LOAD_HALF 6'h07
`define SPT_LAST_HALF 6'h3F
`define SPT_PRE_BLOCK 8'hE8
`define SPT_PRE_SUB0 8'hE2
`define SPT_PRE_SUB1 8'hE4
`define SPT_SYNC_IN 4
`define SPT_STRAP_WAIT 3'h4

`endif

/* pkg/spt_pkg.sv */
// Types shared by the S/PDIF transmit subframe builder
package spt_pkg;
  // Serializer run state
  typedef enum logic {
    SPT_OFF,
    SPT_RUN
  } spt_state_t;
endpackage

/* verilog/spt_fifo.sv */
// Sample FIFO with valid/ready on both sides
module spt_fifo #(
  parameter int W = 27,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D];  // Storage
  logic [AW-1:0] wr_ptr_reg;  // Write pointer
  logic [AW-1:0] rd_ptr_reg;  // Read pointer
  logic [CW-1:0] count_reg;  // Occupancy
  logic push;
  logic pop;

  assign in_ready = (count_reg != CW'(D));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  // Storage write
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : AW'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
        count_reg <= CW'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= CW'(count_reg - 1'b1);
      end
    end
  end
endmodule

/* verilog/spt_tx.sv */
// S/PDIF transmit subframe builder with register file and biphase-mark output
`include "spt_defines.svh"
module spt_tx
  import spt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic hw_mode,
  input wire logic select_or_output1_pin,
  input wire logic recovered_pll_clock,
  input wire logic mclk_pin,
  input wire logic [23:0] rx_sample,
  input wire logic rx_validity,
  input wire logic rx_user,
  input wire logic rx_status,
  input wire logic rx_sample_valid,
  output logic rx_sample_ready,
  input wire logic [23:0] aif_sample,
  input wire logic aif_sample_valid,
  output logic aif_sample_ready,
  output logic serial_audio_out_pin
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] tx_validity_control_reg;  // Validity override
  logic [7:0] tx_status_format_bits_reg;  // Status bits 7:0
  logic [7:0] tx_status_category_reg;  // Status bits 15:8
  logic [7:0] tx_status_source_channel_reg;  // Status bits 23:16
  logic [7:0] tx_source_select_reg;  // Sources, status bits 29:24
  logic [7:0] rx_high_rate_enable_reg;  // Stored only
  logic [7:0] power_down_control_reg;  // Power-down bits
  logic [7:0] rdata_reg;  // Read data
  logic [2:0] strap_cnt_reg;  // Wait until the filtered strap levels have settled
  logic strap_done_reg;  // Strap latched once

  // Decoded controls
  logic tx_payload_source;
  logic tx_status_source;
  logic validity_override_en;
  logic validity_value_sub0;
  logic validity_value_sub1;
  logic tx_power_down;
  logic use_regs;

  assign tx_payload_source = tx_source_select_reg[`SPT_SRC_BIT];
  assign tx_status_source = tx_source_select_reg[`SPT_STAT_SRC_BIT];
  assign validity_override_en = tx_validity_control_reg[`SPT_VAL_OVR_BIT];
  assign validity_value_sub0 = tx_validity_control_reg[`SPT_VAL_SUB0_BIT];
  assign validity_value_sub1 = tx_validity_control_reg[`SPT_VAL_SUB1_BIT];
  assign tx_power_down = power_down_control_reg[`SPT_TX_PD_BIT];
  assign use_regs = tx_payload_source || tx_status_source;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`SPT_SYNC_IN-1:0] pin_in;  // Raw asynchronous inputs
  logic [`SPT_SYNC_IN-1:0] pin_lvl;  // Filtered levels
  assign pin_in = {mclk_pin, recovered_pll_clock, select_or_output1_pin, hw_mode};

  genvar gi;
  generate
    for (gi = 0; gi < `SPT_SYNC_IN; gi++) begin : g_sync
      logic s1_reg;  // First stage, read only by second
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;  // Accepted level
      // Three stages, change taken when the last two agree
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= pin_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign pin_lvl[gi] = lvl_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reference clock edge
  // ----------------------------------------------------------------
  logic ref_prev_reg;  // Previous reference level
  logic ref_lvl;
  logic tick;  // One half bit cell
  assign ref_lvl = tx_payload_source ? pin_lvl[3] : pin_lvl[2];
  assign tick = ref_lvl && !ref_prev_reg;

  // Edge detector on the selected reference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_prev_reg <= 1'b0;
    end else if (ce) begin
      ref_prev_reg <= ref_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and reset strap
  // ----------------------------------------------------------------
  // Write decode; source bit may be set from the strap once after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_validity_control_reg <= `SPT_RST_VALIDITY;
      tx_status_format_bits_reg <= `SPT_RST_FORMAT;
      tx_status_category_reg <= `SPT_RST_CATEGORY;
      tx_status_source_channel_reg <= `SPT_RST_SRC_CHAN;
      tx_source_select_reg <= `SPT_RST_SOURCE;
      rx_high_rate_enable_reg <= `SPT_RST_HIGH_RATE;
      power_down_control_reg <= `SPT_RST_POWER;
      strap_cnt_reg <= 3'h0;
      strap_done_reg <= 1'b0;
    end else if (ce) begin
      if (!strap_done_reg) begin
        // Straps pass the synchroniser before they are taken
        if (strap_cnt_reg == `SPT_STRAP_WAIT) begin
          strap_done_reg <= 1'b1;
          if (pin_lvl[0]) begin
            tx_source_select_reg[`SPT_SRC_BIT] <= pin_lvl[1];
          end
        end else begin
          strap_cnt_reg <= 3'(strap_cnt_reg + 1'b1);
        end
      end else if (reg_wr) begin
        if (reg_addr == `SPT_ADDR_VALIDITY) begin
          tx_validity_control_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_FORMAT) begin
          tx_status_format_bits_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_CATEGORY) begin
          tx_status_category_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_SRC_CHAN) begin
          tx_status_source_channel_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_SOURCE) begin
          tx_source_select_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_HIGH_RATE) begin
          rx_high_rate_enable_reg <= reg_wdata;
        end else if (reg_addr == `SPT_ADDR_POWER) begin
          power_down_control_reg <= reg_wdata;
        end
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (ce && reg_rd) begin
      if (reg_addr == `SPT_ADDR_VALIDITY) begin
        rdata_reg <= tx_validity_control_reg;
      end else if (reg_addr == `SPT_ADDR_FORMAT) begin
        rdata_reg <= tx_status_format_bits_reg;
      end else if (reg_addr == `SPT_ADDR_CATEGORY) begin
        rdata_reg <= tx_status_category_reg;
      end else if (reg_addr == `SPT_ADDR_SRC_CHAN) begin
        rdata_reg <= tx_status_source_channel_reg;
      end else if (reg_addr == `SPT_ADDR_SOURCE) begin
        rdata_reg <= tx_source_select_reg;
      end else if (reg_addr == `SPT_ADDR_HIGH_RATE) begin
        rdata_reg <= rx_high_rate_enable_reg;
      end else if (reg_addr == `SPT_ADDR_POWER) begin
        rdata_reg <= power_down_control_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Input holding stage and FIFO
  // ----------------------------------------------------------------
  logic [`SPT_WORD_W-1:0] hold_reg;  // Accepted word {c,u,v,sample}
  logic hold_full_reg;
  logic rx_ready_reg;
  logic aif_ready_reg;
  logic accept;
  logic fifo_in_ready;
  logic take;
  logic hold_full_next;
  logic fo_valid;
  logic fo_ready;
  logic [`SPT_WORD_W-1:0] fo_data;

  assign accept = (rx_sample_valid && rx_ready_reg) || (aif_sample_valid && aif_ready_reg);
  assign take = hold_full_reg && fifo_in_ready;
  assign hold_full_next = (hold_full_reg && !take) || accept;

  // Latch one word from the selected source, refill readiness
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= '0;
      hold_full_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      aif_ready_reg <= 1'b0;
    end else if (ce) begin
      if (rx_sample_valid && rx_ready_reg) begin
        hold_reg <= {rx_status, rx_user, rx_validity, rx_sample};
      end else if (aif_sample_valid && aif_ready_reg) begin
        hold_reg <= {3'h0, aif_sample};
      end
      hold_full_reg <= hold_full_next;
      rx_ready_reg <= !hold_full_next && !tx_power_down && !tx_payload_source;
      aif_ready_reg <= !hold_full_next && !tx_power_down && tx_payload_source;
    end
  end
  assign rx_sample_ready = rx_ready_reg;
  assign aif_sample_ready = aif_ready_reg;

  spt_fifo #(
    .W(`SPT_WORD_W),
    .D(`SPT_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(hold_full_reg),
    .in_data(hold_reg),
    .in_ready(fifo_in_ready),
    .out_valid(fo_valid),
    .out_data(fo_data),
    .out_ready(fo_ready)
  );

  // ----------------------------------------------------------------
  // Subframe content
  // ----------------------------------------------------------------
  spt_state_t st_reg;  // Serializer state
  logic [5:0] hc_reg;  // Half cell within subframe
  logic sub_reg;  // Subframe 0 or 1
  logic [7:0] frame_reg;  // Frame within status block
  logic line_reg;  // Output level
  logic inv_reg;  // Level before the preamble
  logic [27:0] bits_reg;  // {p,c,u,v,sample} shifted out
  logic ld;
  logic [39:0] cs_vec;
  logic cs_bit;
  logic word_v;
  logic word_u;
  logic word_c;
  logic [23:0] word_smp;
  logic bit_v;
  logic bit_u;
  logic bit_c;
  logic bit_p;
  logic [7:0] pat;

  assign ld = ce && tick && !tx_power_down && (st_reg == SPT_RUN) && (hc_reg == `SPT_LOAD_HALF);
  assign fo_ready = ld;
  assign word_smp = fo_valid ? fo_data[23:0] : 24'h000000;
  assign word_v = fo_valid && fo_data[24];
  assign word_u = fo_valid && fo_data[25];
  assign word_c = fo_valid && fo_data[26];

  // One vector for both subframes, channel numbers at 23:20
  assign cs_vec = {10'h000, tx_source_select_reg[5:0], tx_status_source_channel_reg,
                   tx_status_category_reg, tx_status_format_bits_reg};
  assign cs_bit = (frame_reg < `SPT_CS_USED) ? cs_vec[frame_reg[5:0]] : 1'b0;

  // Validity, user, status and parity selection
  always_comb begin
    if (validity_override_en) begin
      bit_v = sub_reg ? validity_value_sub1 : validity_value_sub0;
    end else if (tx_payload_source) begin
      bit_v = 1'b0;
    end else begin
      bit_v = word_v;
    end
    bit_u = (!tx_payload_source && !tx_status_source) ? word_u : 1'b0;
    bit_c = use_regs ? cs_bit : word_c;
    bit_p = ^{bit_c, bit_u, bit_v, word_smp};
  end

  // Preamble pattern: block start on frame 0 of subframe 0
  always_comb begin
    if (sub_reg) begin
      pat = `SPT_PRE_SUB1;
    end else if (frame_reg == 8'h00) begin
      pat = `SPT_PRE_BLOCK;
    end else begin
      pat = `SPT_PRE_SUB0;
    end
  end

  // ----------------------------------------------------------------
  // Biphase-mark serializer
  // ----------------------------------------------------------------
  // One half cell per reference edge; preamble, then 28 data slots
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SPT_OFF;
      hc_reg <= 6'h00;
      sub_reg <= 1'b0;
      frame_reg <= 8'h00;
      line_reg <= 1'b0;
      inv_reg <= 1'b0;
      bits_reg <= '0;
    end else if (ce) begin
      if (tx_power_down) begin
        // Disabled: line held low, framing restarts at block start
        st_reg <= SPT_OFF;
        hc_reg <= 6'h00;
        sub_reg <= 1'b0;
        frame_reg <= 8'h00;
        line_reg <= 1'b0;
      end else if (st_reg == SPT_OFF) begin
        st_reg <= SPT_RUN;
      end else if (tick) begin
        hc_reg <= 6'(hc_reg + 1'b1);
        if (hc_reg < `SPT_PRE_HALVES) begin
          // Preamble, polarity follows the previous level
          if (hc_reg == 6'h00) begin
            inv_reg <= line_reg;
            line_reg <= pat[3'h7 - hc_reg[2:0]] ^ line_reg;
          end else begin
            line_reg <= pat[3'h7 - hc_reg[2:0]] ^ inv_reg;
          end
        end else if (!hc_reg[0]) begin
          line_reg <= !line_reg;
        end else begin
          line_reg <= line_reg ^ bits_reg[0];
          bits_reg <= {1'b0, bits_reg[27:1]};
        end
        if (ld) begin
          bits_reg <= {bit_p, bit_c, bit_u, bit_v, word_smp};
        end
        if (hc_reg == `SPT_LAST_HALF) begin
          sub_reg <= !sub_reg;
          if (sub_reg) begin
            frame_reg <= (frame_reg == `SPT_BLOCK_LAST) ? 8'h00 : 8'(frame_reg + 1'b1);
          end
        end
      end
    end
  end
  assign serial_audio_out_pin = line_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pd_line_low: assert property (@(posedge clk) disable iff (rst)
    (ce && tx_power_down) |=> !serial_audio_out_pin)
    else $error("line not low while powered down");

  a_src_ready: assert property (@(posedge clk) disable iff (rst)
    (rx_sample_ready |-> !$past(tx_payload_source)) and (aif_sample_ready |-> $past(tx_payload_source)))
    else $error("ready on unselected source");

  a_val_aif_zero: assert property (@(posedge clk) disable iff (rst)
    (ld && tx_payload_source && !validity_override_en) |=> !bits_reg[24])
    else $error("validity not zero for audio source");

  a_val_rx_copy: assert property (@(posedge clk) disable iff (rst)
    (ld && !tx_payload_source && !validity_override_en) |=> bits_reg[24] == $past(word_v))
    else $error("validity not forwarded");

  a_val_override: assert property (@(posedge clk) disable iff (rst)
    (ld && validity_override_en && !sub_reg) |=> bits_reg[24] == $past(validity_value_sub0))
    else $error("override validity wrong");

  a_user_gate: assert property (@(posedge clk) disable iff (rst)
    (ld && use_regs) |=> !bits_reg[25])
    else $error("user bit not zero");

  a_parity_even: assert property (@(posedge clk) disable iff (rst)
    ld |=> !(^bits_reg))
    else $error("subframe parity odd");

  a_cs_tail_zero: assert property (@(posedge clk) disable iff (rst)
    (ld && use_regs && frame_reg >= `SPT_CS_USED) |=> !bits_reg[26])
    else $error("status bit beyond 40 not zero");

  a_cat_map: assert property (@(posedge clk) disable iff (rst)
    (ld && use_regs && frame_reg[7:3] == 5'h01)
      |=> bits_reg[26] == $past(tx_status_category_reg[frame_reg[2:0]]))
    else $error("category bit mismatch");

  a_pre_toggle: assert property (@(posedge clk) disable iff (rst)
    (ce && tick && !tx_power_down && st_reg == SPT_RUN && hc_reg == 6'h00)
      |=> serial_audio_out_pin != $past(serial_audio_out_pin))
    else $error("preamble did not start with a transition");

  a_strap_latch: assert property (@(posedge clk) disable iff (rst)
    (ce && !strap_done_reg && strap_cnt_reg == `SPT_STRAP_WAIT && pin_lvl[0])
      |=> tx_payload_source == $past(pin_lvl[1]))
    else $error("strap not latched");
endmodule

/* test/spt_rx_model.sv */
// Far-end receiver model: samples half cells and decodes subframes
module spt_rx_model (
  input wire logic ref_clk,
  input wire logic hold,
  input wire logic pin,
  output logic [15:0] sf_count,
  output logic [7:0] sf_pre,
  output logic [31:0] sf_slots,
  output logic [7:0] bmc_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] h; // Half cells of the current subframe
  int idx; // Next half index, -1 skips the edge before half 0
  logic prev; // Line level before the preamble
  // Each reference edge samples the half that just ended
  always @(posedge ref_clk) begin
    if (hold) begin
      idx = -1;
      prev = 1'b0;
      sf_count = 16'h0000;
      bmc_err = 8'h00;
    end else if (idx < 0) begin
      idx = 0;
    end else begin
      h[idx] = pin;
      if (idx == 63) begin
        sf_slots[3:0] = 4'h0;
        for (int s = 4; s < 32; s++) begin
          sf_slots[s] = h[2*s] ^ h[2*s+1];
          if (h[2*s] == h[2*s-1]) bmc_err++;
        end
        for (int j = 0; j < 8; j++) sf_pre[7-j] = h[j] ^ prev;
        prev = h[63];
        sf_count++;
        idx = 0;
      end else begin
        idx++;
      end
    end
  end
endmodule

/* test/tb_top.sv */
// Testbench for the S/PDIF transmit subframe builder
`include "spt_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ref_clk = 0, sel = 1, hold = 1;
  logic hw_mode = 0, strap_pin = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic [23:0] rx_sample = 24'h0, aif_sample = 24'h0;
  logic rx_validity = 0, rx_user = 0, rx_status = 0, rx_sample_valid = 0, aif_sample_valid = 0;
  logic rx_sample_ready, aif_sample_ready, pin, fa = 0, fr = 0, ta, tr;
  logic [15:0] sf_count;
  logic [7:0] sf_pre, bmc_err;
  logic [31:0] sf_slots;
  int num_errors = 0, checks_done = 0, ak = 0, rk = 0, rc = 0;
  logic [7:0] ra [8] = '{8'h1E, 8'h15, 8'h12, 8'h13, 8'h14, 8'h06, 8'h1D, 8'h30};
  logic [7:0] rv [8] = '{8'h06, 8'h71, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  spt_tx spt_tx_inst (.clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_mode(hw_mode), .select_or_output1_pin(strap_pin),
    .recovered_pll_clock(ref_clk & ~sel), .mclk_pin(ref_clk & sel), .rx_sample(rx_sample),
    .rx_validity(rx_validity), .rx_user(rx_user), .rx_status(rx_status), .rx_sample_valid(rx_sample_valid),
    .rx_sample_ready(rx_sample_ready), .aif_sample(aif_sample), .aif_sample_valid(aif_sample_valid),
    .aif_sample_ready(aif_sample_ready), .serial_audio_out_pin(pin));
  spt_rx_model spt_rx_model_inst (.ref_clk(ref_clk), .hold(hold), .pin(pin), .sf_count(sf_count),
    .sf_pre(sf_pre), .sf_slots(sf_slots), .bmc_err(bmc_err));
  // Clock of 4 ns
  initial begin
    forever #2 clk = ~clk;
  end
  // Reference clock: one half cell per 10 clk
  always @(posedge clk) begin
    #1;
    rc = (rc == 4) ? 0 : rc + 1;
    if (rc == 0) ref_clk = ~ref_clk;
  end
  // Sample feeders, a new word after each handshake
  always @(posedge clk) begin
    ta = aif_sample_valid && aif_sample_ready;
    tr = rx_sample_valid && rx_sample_ready;
    #1;
    if (ta) ak++;
    if (tr) rk++;
    aif_sample = smp(ak);
    aif_sample_valid = fa || (aif_sample_valid && !ta);
    rx_sample = smp(rk);
    rx_validity = 1'b1;
    rx_user = 1'b1;
    rx_status = rk[0];
    rx_sample_valid = fr || (rx_sample_valid && !tr);
  end
  function automatic logic [23:0] smp(int k);
    return 24'(24'h5A3C0F ^ (k * 24'h00B1C3));
  endfunction
  function automatic logic cs_bit(int f);
    logic [39:0] v;
    v = {10'h000, 6'h31, 8'h96, 8'h5A, 8'h0E};
    return (f < 40) ? v[f] : 1'b0;
  endfunction
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk) #1;
    reg_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1;
    @(posedge clk) #1;
    reg_rd = 0;
    rd_val = reg_rdata;
  endtask
  // Power up away from a reference edge, the model restarts with it
  task power_up();
    @(negedge ref_clk);
    wr(`SPT_ADDR_POWER, 8'h00);
    hold = 0;
  endtask
  task next_sf(input int n);
    repeat (n) @(sf_count);
  endtask
  task chk_sf(input int n, input logic v, u, c);
    chk({24'h0, sf_pre}, (n % 2) ? 32'hE4 : (n == 0) ? 32'hE8 : 32'hE2);
    chk({8'h00, sf_slots[27:4]}, {8'h00, smp(n)});
    chk({29'h0, sf_slots[30:28]}, {29'h0, c, u, v});
    chk({31'h0, ^sf_slots[31:4]}, 32'h0);
  endtask
  // Reset values, unmapped read, powered-down outputs
  task s_reset();
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      chk({24'h0, rd_val}, {24'h0, rv[i]});
    end
    chk({30'h0, pin, aif_sample_ready}, 32'h0);
  endtask
  // Audio interface source with register status over 40 frames
  task s_audio();
    wr(`SPT_ADDR_FORMAT, 8'h0E);
    wr(`SPT_ADDR_CATEGORY, 8'h5A);
    wr(`SPT_ADDR_SRC_CHAN, 8'h96);
    rd(`SPT_ADDR_SRC_CHAN);
    chk({24'h0, rd_val}, 32'h96);
    fa = 1;
    power_up();
    for (int n = 0; n < 80; n++) begin
      next_sf(1);
      chk_sf(n, 1'b0, 1'b0, cs_bit(n / 2));
    end
    chk({24'h0, bmc_err}, 32'h0);
    fa = 0;
    next_sf(20);
    wr(`SPT_ADDR_POWER, 8'h06);
    hold = 1;
    repeat (8) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
  endtask
  // Receiver source: forwarding, then override, then register status
  task s_rx();
    wr(`SPT_ADDR_SOURCE, 8'h31);
    sel = 0;
    fr = 1;
    power_up();
    for (int n = 0; n < 16; n++) begin
      next_sf(1);
      if (n < 4) chk_sf(n, 1'b1, 1'b1, n[0]);
      if (n == 4) wr(`SPT_ADDR_VALIDITY, 8'hA0);
      if (n > 5 && n < 10) chk_sf(n, ~n[0], 1'b1, n[0]);
      if (n == 10) wr(`SPT_ADDR_SOURCE, 8'hB1);
      if (n > 11) chk_sf(n, ~n[0], 1'b0, cs_bit(n / 2));
    end
  endtask
  // Mid-run reset in hardware mode: strap sets the payload source
  task s_strap();
    hw_mode = 1;
    @(posedge clk) #1;
    rst = 1;
    repeat (5) @(posedge clk);
    #1 rst = 0;
    repeat (6) @(posedge clk);
    #1;
    chk({30'h0, pin, rx_sample_ready}, 32'h0);
    rd(`SPT_ADDR_SOURCE);
    chk({24'h0, rd_val}, 32'h31);
  endtask
  task conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #360us;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    repeat (6) @(posedge clk);
    s_reset();
    s_audio();
    s_rx();
    s_strap();
    conclude();
  end
endmodule
